// [rtl/oad_pkg.sv]
/*
  Shared constants for the operand and address development stage:
  register file layout, field widths, operand sizes, instruction kinds.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package oad_pkg;
  // ---------------------------------------------------------------
  // Register file layout
  // ---------------------------------------------------------------
  localparam int          RF_WORDS  = 48;
  localparam logic [5:0]  IDX_BASE  = 6'h20;  // Index group 20..27
  localparam logic [5:0]  VEC_BASE  = 6'h28;  // Vector group 28..2F
  localparam logic [5:0]  RF_LIMIT  = 6'h2F;  // Top register address
  localparam logic [31:0] RF_RESET  = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Address widths
  // ---------------------------------------------------------------
  localparam int EA_W   = 25;  // Effective address, halfword units
  localparam int BASE_W = 24;
  localparam int DISP_W = 12;
  localparam int CA_W   = 21;  // Octet address to requestor
  // ---------------------------------------------------------------
  // Operand sizes and instruction kinds
  // ---------------------------------------------------------------
  localparam logic [1:0] SZ_HALF = 2'h0;
  localparam logic [1:0] SZ_SNGL = 2'h1;
  localparam logic [1:0] SZ_DBL  = 2'h2;
  localparam logic [1:0] K_OPND  = 2'h0;  // Memory or register operand
  localparam logic [1:0] K_IMM   = 2'h1;  // Immediate operand
  localparam logic [1:0] K_BR    = 2'h2;  // Branch target
  localparam logic [1:0] K_BRT   = 2'h3;  // Branch on register greater
endpackage : oad_pkg

// [rtl/operand_address_develop.sv]
/*
  Operand and address development stage: register file, level-2 latches,
  level-3 index adder, indirect chain, immediates, branch targets and the
  level-3 branch test adder. Assumes decode drives one instruction per
  issue pulse while ready is high, and that memory answers a request with
  one mem_valid pulse carrying the octet. All inputs are on clk.
*/
// The register offsets and the address-and-strobe port are this design's own decisions.
module operand_address_develop (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          clk_en,
  input  wire logic          issue,
  output logic               ready,
  input  wire logic [1:0]    kind,
  input  wire logic [1:0]    word_size,
  input  wire logic          imm_arith,
  input  wire logic [1:0]    group_sel,
  input  wire logic [3:0]    r_field,
  input  wire logic          half_sel,
  input  wire logic [3:0]    t_field,
  input  wire logic [3:0]    m_field,
  input  wire logic [11:0]   n_field,
  input  wire logic [23:0]   prog_counter,
  input  wire logic          in_xy,
  output logic               mem_req,
  output logic [20:0]        mem_octet_addr,
  input  wire logic          mem_valid,
  input  wire logic [255:0]  mem_octet,
  output logic               ca_valid,
  output logic [20:0]        ca_addr,
  output logic               wsel_valid,
  output logic [3:0]         wsel_bits,
  output logic               opnd_valid,
  output logic [63:0]        address_operand_latch,
  output logic [63:0]        register_operand_latch,
  output logic               branch_valid,
  output logic [24:0]        branch_target,
  output logic               branch_test_true,
  input  wire logic          rf_we,
  input  wire logic          rf_re,
  input  wire logic          rf_group,
  input  wire logic [5:0]    rf_addr,
  input  wire logic [255:0]  rf_wdata,
  output logic [255:0]       rf_rdata
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_CALC = 5'b0_0010,
    ST_MREQ = 5'b0_0100,
    ST_IDEC = 5'b0_1000,
    ST_EMIT = 5'b1_0000
  } state_e;

  typedef struct packed {
    state_e             st;
    logic [24:0]        pre_index_latch;
    logic [23:0]        base_select_latch;
    logic [11:0]        displacement_latch;
    logic [3:0]         m;
    logic [3:0]         t;
    logic [1:0]         kind;
    logic [1:0]         ws;
    logic               arith;
    logic               ind;
    logic               half;
    logic [5:0]         raddr;
    logic               first;
    logic               xy;
    logic [24:0]        effective_address_reg;
    logic [24:0]        prefetch_pointer;
    logic [255:0]       memory_sync_instr_file;
    logic [31:0]        instruction_holding_reg;
    logic [63:0]        a0;
    logic [63:0]        r0;
    logic               op_v;
    logic               ca_v;
    logic               ws_v;
    logic               br_v;
    logic               bt;
    logic [255:0]       rd;
    logic [47:0][31:0]  rf;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic [47:0] word_we;

  // ---------------------------------------------------------------
  // Register file write enables, one per entry
  // ---------------------------------------------------------------
  // Group writes take the eight entries sharing rf_addr[5:3]
  generate
    for (genvar i = 0; i < oad_pkg::RF_WORDS; i++) begin : g_we
      localparam logic [5:0] IDX = 6'(i);
      assign word_we[i] = rf_we && (rf_group ? (rf_addr[5:3] == IDX[5:3]) : (rf_addr == IDX));
    end
  endgenerate

  // Read one register; addresses beyond 2F read as zero
  function automatic logic [31:0] rd_reg(input logic [47:0][31:0] f, input logic [5:0] a);
    rd_reg = (a <= oad_pkg::RF_LIMIT) ? f[a] : 32'h0000_0000;
  endfunction : rd_reg

  // Operand left-justified by size: half in 63:48, single in 63:32
  function automatic logic [63:0] rd_opnd(input logic [47:0][31:0] f, input logic [5:0] a,
                                          input logic h, input logic [1:0] ws);
    logic [31:0] w;
    w = rd_reg(f, a);
    if (ws == oad_pkg::SZ_DBL) begin
      rd_opnd = {rd_reg(f, {a[5:1], 1'b0}), rd_reg(f, {a[5:1], 1'b1})};
    end else if (ws == oad_pkg::SZ_HALF) begin
      rd_opnd = {(h ? w[15:0] : w[31:16]), 48'h0000_0000_0000};
    end else begin
      rd_opnd = {w, 32'h0000_0000};
    end
  endfunction : rd_opnd

  // Word-size forcing of the effective address low bits
  function automatic logic [24:0] force_ea(input logic [24:0] e, input logic [1:0] ws);
    if (ws == oad_pkg::SZ_DBL) begin
      force_ea = {e[24:2], 2'b00};
    end else if (ws == oad_pkg::SZ_SNGL) begin
      force_ea = {e[24:1], 1'b0};
    end else begin
      force_ea = e;
    end
  endfunction : force_ea

  // Pre-index shift by word size
  function automatic logic [24:0] shift_x(input logic [24:0] x, input logic [1:0] ws);
    if (ws == oad_pkg::SZ_HALF) begin
      shift_x = x >> 1;
    end else if (ws == oad_pkg::SZ_DBL) begin
      shift_x = x << 1;
    end else begin
      shift_x = x;
    end
  endfunction : shift_x

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic [24:0] idx_sum;
  logic [24:0] ea_calc;
  logic [31:0] imm_ext;
  logic [31:0] imm_sum;
  logic [31:0] bt_sum;
  logic [31:0] ind_idx;
  logic [24:0] ind_target;
  logic        ea_low;
  logic [5:0]  t_addr;
  logic [31:0] base_word;

  always_comb begin
    s_nxt = s_r;
    // Base register word, cut to the 24-bit latch below
    base_word = rd_reg(s_r.rf, {2'b00, m_field});
    idx_sum = 25'(shift_x(s_r.pre_index_latch, s_r.ws) + {1'b0, s_r.base_select_latch}
                  + {13'h0000, s_r.displacement_latch});
    ea_calc = (s_r.kind == oad_pkg::K_BR) ? idx_sum : force_ea(idx_sum, s_r.ws);
    // Low address window of the register file, singleword part in 6:1
    ea_low = (s_r.effective_address_reg[24:7] == 18'h0_0000);
    imm_ext = s_r.arith ? {{16{s_r.m[3]}}, s_r.m, s_r.displacement_latch}
                        : {16'h0000, s_r.m, s_r.displacement_latch};
    imm_sum = rd_reg(s_r.rf, oad_pkg::IDX_BASE | {3'b000, s_r.t[2:0]}) + imm_ext;
    t_addr = {s_r.raddr[5:4], s_r.t};
    // Ones'-complement sum: R + T + ~(T+1)
    bt_sum = rd_reg(s_r.rf, s_r.raddr) + rd_reg(s_r.rf, t_addr)
             + ~rd_reg(s_r.rf, 6'(t_addr + 6'h01));
    ind_idx = rd_reg(s_r.rf, oad_pkg::IDX_BASE | {3'b000, s_r.instruction_holding_reg[26:24]});
    ind_target = {1'b0, s_r.instruction_holding_reg[23:0]} + 25'(ind_idx[23:0]);
    // Output pulses last one cycle
    s_nxt.op_v = 1'b0;
    s_nxt.ca_v = 1'b0;
    s_nxt.ws_v = 1'b0;
    s_nxt.br_v = 1'b0;
    // Register file access from the store/load port
    for (int i = 0; i < oad_pkg::RF_WORDS; i++) begin
      if (word_we[i]) begin
        s_nxt.rf[i] = rf_group ? rf_wdata[255 - 32 * (i % 8) -: 32] : rf_wdata[31:0];
      end
    end
    if (rf_re) begin
      s_nxt.rd = 256'h0;
      for (int j = 0; j < 8; j++) begin
        s_nxt.rd[255 - 32 * j -: 32] = rf_group ? rd_reg(s_r.rf, {rf_addr[5:3], 3'(j)})
                                                : ((j == 7) ? rd_reg(s_r.rf, rf_addr) : 32'h0000_0000);
      end
    end
    case (s_r.st)
      ST_IDLE: begin
        if (issue) begin
          // Level 2: index, base and displacement latches
          s_nxt.pre_index_latch = 25'(rd_reg(s_r.rf, oad_pkg::IDX_BASE | {3'b000, t_field[2:0]}));
          s_nxt.base_select_latch = (kind == oad_pkg::K_BR && m_field == 4'h0) ? prog_counter
                                    : base_word[23:0];
          s_nxt.displacement_latch = n_field;
          s_nxt.ind = t_field[3];
          s_nxt.m = m_field;
          s_nxt.t = t_field;
          s_nxt.kind = kind;
          s_nxt.ws = word_size;
          s_nxt.arith = imm_arith;
          s_nxt.half = half_sel;
          s_nxt.raddr = {group_sel, r_field};
          s_nxt.first = 1'b1;
          s_nxt.xy = in_xy;
          s_nxt.st = ST_CALC;
        end
      end
      ST_CALC: begin
        if (s_r.kind == oad_pkg::K_IMM) begin
          s_nxt.a0 = (s_r.ws == oad_pkg::SZ_HALF) ? {16'h0000, imm_sum[15:0], 32'h0000_0000}
                                                 : {imm_sum, 32'h0000_0000};
          s_nxt.r0 = rd_opnd(s_r.rf, s_r.raddr, s_r.half, s_r.ws);
          s_nxt.op_v = 1'b1;
          s_nxt.st = ST_IDLE;
        end else if (s_r.kind == oad_pkg::K_BRT) begin
          s_nxt.a0 = {rd_reg(s_r.rf, t_addr), rd_reg(s_r.rf, 6'(t_addr + 6'h01))};
          s_nxt.r0 = {rd_reg(s_r.rf, s_r.raddr), 32'h0000_0000};
          s_nxt.bt = ~bt_sum[31];
          s_nxt.op_v = 1'b1;
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.effective_address_reg = ea_calc;
          s_nxt.st = ST_EMIT;
          if (s_r.ind) begin
            s_nxt.prefetch_pointer = ea_calc;
            s_nxt.st = ST_MREQ;
          end
        end
      end
      ST_MREQ: begin
        // First level may come from the register file, never for branches
        if (s_r.first && ea_low && s_r.effective_address_reg[6:1] <= oad_pkg::RF_LIMIT
            && s_r.m == 4'h0 && s_r.kind != oad_pkg::K_BR) begin
          s_nxt.instruction_holding_reg = rd_reg(s_r.rf, s_r.effective_address_reg[6:1]);
          s_nxt.first = 1'b0;
          s_nxt.st = ST_IDEC;
        end else if (mem_valid) begin
          s_nxt.memory_sync_instr_file = mem_octet;
          s_nxt.instruction_holding_reg = mem_octet[255 - 32 * s_r.effective_address_reg[3:1] -: 32];
          s_nxt.first = 1'b0;
          s_nxt.st = ST_IDEC;
        end
      end
      ST_IDEC: begin
        if (s_r.instruction_holding_reg[27]) begin
          // Further level: singleword memory address
          s_nxt.effective_address_reg = {ind_target[23:0], 1'b0};
          s_nxt.prefetch_pointer = {ind_target[23:0], 1'b0};
          s_nxt.st = ST_MREQ;
        end else begin
          // Terminal: index scaled by the instruction word size
          s_nxt.effective_address_reg = force_ea(25'({s_r.instruction_holding_reg[23:0], 1'b0}
                                        + shift_x(25'(ind_idx[24:0]), s_r.ws)), s_r.ws);
          s_nxt.st = ST_EMIT;
        end
      end
      ST_EMIT: begin
        s_nxt.r0 = rd_opnd(s_r.rf, s_r.raddr, s_r.half, s_r.ws);
        if (s_r.kind == oad_pkg::K_BR) begin
          s_nxt.br_v = 1'b1;
        end else if (!s_r.ind && ea_low && s_r.effective_address_reg[6:1] < oad_pkg::RF_LIMIT
                     && s_r.m == 4'h0) begin
          s_nxt.a0 = rd_opnd(s_r.rf, s_r.effective_address_reg[6:1],
                             s_r.effective_address_reg[0], s_r.ws);
          s_nxt.op_v = 1'b1;
        end else if (s_r.xy) begin
          s_nxt.ws_v = 1'b1;
        end else begin
          s_nxt.ca_v = 1'b1;
        end
        s_nxt.st = ST_IDLE;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Clock enable low freezes everything, including the register file
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign ready                  = (s_r.st == ST_IDLE);
  assign mem_req                = (s_r.st == ST_MREQ) && !(s_r.first && s_r.m == 4'h0 && s_r.kind != oad_pkg::K_BR
                                  && s_r.effective_address_reg[24:7] == 18'h0_0000
                                  && s_r.effective_address_reg[6:1] <= oad_pkg::RF_LIMIT);
  assign mem_octet_addr         = s_r.prefetch_pointer[24:4];
  assign ca_valid               = s_r.ca_v;
  assign ca_addr                = s_r.effective_address_reg[24:4];
  assign wsel_valid             = s_r.ws_v;
  assign wsel_bits              = s_r.effective_address_reg[3:0];
  assign opnd_valid             = s_r.op_v;
  assign address_operand_latch  = s_r.a0;
  assign register_operand_latch = s_r.r0;
  assign branch_valid           = s_r.br_v;
  assign branch_target          = s_r.effective_address_reg;
  assign branch_test_true       = s_r.bt;
  assign rf_rdata               = s_r.rd;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_group_write: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && rf_we && rf_group && rf_addr[5:3] == 3'h1 |=> s_r.rf[15] == $past(rf_wdata[31:0]))
    else $error("group write missed last entry");
  a_single_force: assert property (@(posedge clk) disable iff (!reset_n)
    (ca_valid || wsel_valid) && s_r.ws == oad_pkg::SZ_SNGL |-> s_r.effective_address_reg[0] == 1'b0)
    else $error("singleword address low bit set");
  a_dbl_force: assert property (@(posedge clk) disable iff (!reset_n)
    (ca_valid || wsel_valid) && s_r.ws == oad_pkg::SZ_DBL |-> s_r.effective_address_reg[1:0] == 2'b00)
    else $error("doubleword address low bits set");
  a_pulse_once: assert property (@(posedge clk) disable iff (!reset_n)
    ca_valid && clk_en |=> !ca_valid)
    else $error("request pulse held");
  a_hit_miss: assert property (@(posedge clk) disable iff (!reset_n)
    !(ca_valid && wsel_valid))
    else $error("requestor and word select together");
  a_ind_fetch: assert property (@(posedge clk) disable iff (!reset_n)
    mem_req && mem_valid && clk_en |=> s_r.st == ST_IDEC
      && s_r.instruction_holding_reg == $past(mem_octet[255 - 32 * s_r.effective_address_reg[3:1] -: 32]))
    else $error("indirect word not captured");
  a_ind_chain: assert property (@(posedge clk) disable iff (!reset_n)
    s_r.st == ST_IDEC && s_r.instruction_holding_reg[27] && clk_en |=> mem_req)
    else $error("next indirect level not requested");
  a_br_no_rf: assert property (@(posedge clk) disable iff (!reset_n)
    s_r.st == ST_MREQ && s_r.kind == oad_pkg::K_BR |-> mem_req)
    else $error("indirect branch used register file");
  a_bt_sign: assert property (@(posedge clk) disable iff (!reset_n)
    s_r.st == ST_CALC && s_r.kind == oad_pkg::K_BRT && clk_en |=> opnd_valid && branch_test_true == !$past(bt_sum[31]))
    else $error("branch test sign wrong");
  a_imm_done: assert property (@(posedge clk) disable iff (!reset_n)
    ready && issue && kind == oad_pkg::K_IMM && clk_en ##1 clk_en |=> opnd_valid)
    else $error("immediate result late");
  c_mem_ind: cover property (@(posedge clk) disable iff (!reset_n) mem_req && mem_valid);
  c_branch: cover property (@(posedge clk) disable iff (!reset_n) branch_valid);
  c_ca_req: cover property (@(posedge clk) disable iff (!reset_n) ca_valid);
  c_bt_true: cover property (@(posedge clk) disable iff (!reset_n) opnd_valid && branch_test_true);
endmodule : operand_address_develop

// [dv/octet_memory_model.sv]
/*
  Behavioural model of the memory side that answers indirect octet requests.
  Assumes one clock domain, a request held until answered, and a table of four
  octets that the bench preloads, picked by the two low octet address bits.
*/
module octet_memory_model (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         mem_req,
  input  wire logic [20:0]  mem_octet_addr,
  input  wire logic [3:0]   lat,
  output logic              mem_valid,
  output logic [255:0]      mem_octet
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [255:0] oct [4];
  logic [3:0]   wait_r;
  // Answer after lat idle cycles; the data bus toggles when not valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_valid <= 1'b0;
      mem_octet <= '0;
      wait_r    <= 4'h0;
    end else if (mem_req && !mem_valid && wait_r >= lat) begin
      mem_valid <= 1'b1;
      mem_octet <= oct[mem_octet_addr[1:0]];
      wait_r    <= 4'h0;
    end else begin
      mem_valid <= 1'b0;
      mem_octet <= ~mem_octet;  // No stale octet left for a lucky match
      wait_r    <= (mem_req && !mem_valid) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule : octet_memory_model

// [dv/operand_address_develop_tb.sv]
/*
  Self-checking bench for the operand and address development stage.
  Assumes the octet memory model and one instruction in flight at a time.
*/
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module operand_address_develop_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, issue = 0, imm_arith = 0, in_xy = 0, rf_we = 0, rf_re = 0, rf_group = 0;
  logic [1:0] kind = '0, word_size = '0;
  logic [3:0] t_field = '0, m_field = '0, lat = 4'h6;
  logic [11:0] n_field = '0;
  logic [5:0] rf_addr = '0;
  logic [255:0] rf_wdata = '0, rf_rdata, mem_octet;
  logic ready, mem_req, mem_valid, ca_valid, wsel_valid, opnd_valid, branch_valid, branch_test_true;
  logic [20:0] mem_octet_addr, ca_addr;
  logic [3:0] wsel_bits;
  logic [63:0] aol, rol;
  logic [24:0] branch_target;
  logic [20:0] reqs[$];
  int miscompares = 0, samples_checked = 0;
  always #5 clk = ~clk;
  operand_address_develop DUT (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .issue(issue), .ready(ready),
    .kind(kind), .word_size(word_size), .imm_arith(imm_arith), .group_sel(2'h2), .r_field(4'h2),
    .half_sel(1'b0), .t_field(t_field), .m_field(m_field), .n_field(n_field), .prog_counter(24'h00_1000),
    .in_xy(in_xy), .mem_req(mem_req), .mem_octet_addr(mem_octet_addr), .mem_valid(mem_valid),
    .mem_octet(mem_octet), .ca_valid(ca_valid), .ca_addr(ca_addr), .wsel_valid(wsel_valid),
    .wsel_bits(wsel_bits), .opnd_valid(opnd_valid), .address_operand_latch(aol),
    .register_operand_latch(rol), .branch_valid(branch_valid), .branch_target(branch_target),
    .branch_test_true(branch_test_true), .rf_we(rf_we), .rf_re(rf_re), .rf_group(rf_group),
    .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));
  octet_memory_model mem (.clk(clk), .reset_n(reset_n), .mem_req(mem_req), .mem_octet_addr(mem_octet_addr),
    .lat(lat), .mem_valid(mem_valid), .mem_octet(mem_octet));
  // Log every octet address the memory side accepts
  always @(posedge clk) begin
    if (mem_req === 1'b1 && mem_valid === 1'b1) reqs.push_back(mem_octet_addr);
  end
  task automatic complete_run();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [5:0] a, input logic g, input logic [255:0] d);
    @(posedge clk);
    rf_we <= 1'b1;
    rf_group <= g;
    rf_addr <= a;
    rf_wdata <= d;
    @(posedge clk);
    rf_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic g, output logic [255:0] q);
    @(posedge clk);
    rf_re <= 1'b1;
    rf_group <= g;
    rf_addr <= a;
    @(posedge clk);
    rf_re <= 1'b0;
    #1;
    q = rf_rdata;
  endtask : rd
  // One instruction, then a bounded wait for its output pulse
  task automatic iss(input logic [1:0] k, ws, input logic [3:0] t, m, input logic [11:0] n, input logic xy, ia);
    int w;
    @(posedge clk);
    issue <= 1'b1;
    kind <= k;
    word_size <= ws;
    t_field <= t;
    m_field <= m;
    n_field <= n;
    in_xy <= xy;
    imm_arith <= ia;
    @(posedge clk);
    issue <= 1'b0;
    w = 0;
    do begin
      @(posedge clk);
      #1;
      w++;
    end while ((ca_valid | wsel_valid | opnd_valid | branch_valid) !== 1'b1 && w < 200);
    if (w >= 200) begin
      miscompares++;
      complete_run();
    end
  endtask : iss
  // Expected address: base + displacement + size-shifted index, low bits forced
  function automatic logic [24:0] ea(input logic [1:0] ws, input logic [24:0] x, b, n);
    logic [24:0] s;
    s = b + n + (ws == oad_pkg::SZ_HALF ? x >> 1 : ws == oad_pkg::SZ_DBL ? x << 1 : x);
    if (ws == oad_pkg::SZ_SNGL) s[0] = 1'b0;
    if (ws == oad_pkg::SZ_DBL) s[1:0] = 2'b00;
    return s;
  endfunction : ea
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [255:0] q, g;
    logic [24:0]  e;
    for (int j = 0; j < 8; j++) g[255-32*j -: 32] = (j == 2) ? 32'h0700_0300 : 32'h1234_0000 + j;
    mem.oct[1] = {32'h0F00_0098, 224'h0};
    mem.oct[3] = {32'h0700_0200, 224'h0};
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wr(6'h08, 1'b1, g);
    wr(6'h20, 1'b0, 256'h8);
    wr(6'h01, 1'b0, 256'h100);
    wr(6'h22, 1'b0, 256'h5);
    wr(6'h23, 1'b0, 256'h3);
    wr(6'h24, 1'b0, 256'h8);
    wr(6'h30, 1'b0, 256'hFFFF);
    rd(6'h08, 1'b1, q);
    `CHK("group read", g, q)
    rd(6'h0B, 1'b0, q);
    `CHK("single read", {224'h0, g[159:128]}, q)
    rd(6'h30, 1'b0, q);
    `CHK("beyond file", 256'h0, q)
    for (logic [1:0] s = 0; s < 3; s++) begin
      e = ea(s, 25'h8, 25'h100, 25'h21);
      iss(oad_pkg::K_OPND, s, 4'h0, 4'h1, 12'h021, s[0], 1'b0);
      if (s[0]) `CHK("word select", {1'b1, e[3:0]}, {wsel_valid, wsel_bits})
      else `CHK("requestor", {1'b1, e[24:4]}, {ca_valid, ca_addr})
    end
    iss(oad_pkg::K_IMM, oad_pkg::SZ_SNGL, 4'h0, 4'h8, 12'h001, 1'b0, 1'b1);
    `CHK("imm arith", {1'b1, 32'hFFFF_8009}, {opnd_valid, aol[63:32]})
    iss(oad_pkg::K_IMM, oad_pkg::SZ_SNGL, 4'h0, 4'h8, 12'h001, 1'b0, 1'b0);
    `CHK("imm logic", {1'b1, 32'h0000_8009}, {opnd_valid, aol[63:32]})
    iss(oad_pkg::K_BR, oad_pkg::SZ_SNGL, 4'h0, 4'h0, 12'h000, 1'b0, 1'b0);
    `CHK("pc branch", {1'b1, 25'h1008}, {branch_valid, branch_target})
    iss(oad_pkg::K_BR, oad_pkg::SZ_SNGL, 4'h0, 4'h1, 12'h000, 1'b0, 1'b0);
    `CHK("base branch", {1'b1, 25'h0108}, {branch_valid, branch_target})
    iss(oad_pkg::K_OPND, oad_pkg::SZ_SNGL, 4'h0, 4'h0, 12'h00E, 1'b0, 1'b0);
    `CHK("file operand", {1'b1, g[159:128], 32'h5}, {opnd_valid, aol[63:32], rol[63:32]})
    iss(oad_pkg::K_OPND, oad_pkg::SZ_DBL, 4'h0, 4'h0, 12'h00C, 1'b0, 1'b0);
    `CHK("file double", {1'b1, g[63:0], 32'h5, 32'h3}, {opnd_valid, aol, rol})
    iss(oad_pkg::K_BRT, oad_pkg::SZ_SNGL, 4'h3, 4'h0, 12'h000, 1'b0, 1'b0);
    `CHK("test false", 2'b10, {opnd_valid, branch_test_true})
    wr(6'h24, 1'b0, 256'h7);
    iss(oad_pkg::K_BRT, oad_pkg::SZ_SNGL, 4'h3, 4'h0, 12'h000, 1'b0, 1'b0);
    `CHK("test true", 2'b11, {opnd_valid, branch_test_true})
    iss(oad_pkg::K_OPND, oad_pkg::SZ_SNGL, 4'hF, 4'h1, 12'h010, 1'b0, 1'b0);
    `CHK("chain end", {1'b1, 21'h40, 1'b1}, {ca_valid, ca_addr, ready})
    `CHK("chain fetches", {32'd2, 21'h11, 21'h13}, {reqs.size(), reqs[0], reqs[1]})
    iss(oad_pkg::K_OPND, oad_pkg::SZ_SNGL, 4'hF, 4'h0, 12'h014, 1'b0, 1'b0);
    `CHK("file indirect", {1'b1, 21'h60, 32'd2}, {ca_valid, ca_addr, reqs.size()})
    complete_run();
  end
endmodule : operand_address_develop_tb
